//--- hw/ujp_defs.vh
// Purpose: Shared constants for the user test port bridge
// Assumes: Included by the bridge only; the synchroniser does not include it
// Notes: Instruction codes are 8 bits wide
`ifndef UJP_DEFS_VH
`define UJP_DEFS_VH

// Instruction register layout
`define UJP_IR_W 8
`define UJP_IR_CAPTURE 8'h01
`define UJP_IR_RESET 8'h0f
`define UJP_OP_IDCODE 8'h0f
`define UJP_OP_BYPASS 8'hff

// User instruction range, inclusive
`define UJP_USER_LO 8'h10
`define UJP_USER_HI 8'h7f

// Identification register, value is arbitrary
`define UJP_ID_W 32
`define UJP_ID_VALUE 32'h0a5a_5001

// Synchroniser depth
`define UJP_SYNC_STAGES 2

`endif

//--- hw/ujp_sync.v
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: The first stage feeds only the second stage
`default_nettype none

module ujp_sync #(
   parameter W = 4
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Pin side
   input wire [W-1:0] async_in,
   // Clock domain side
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // Two flops per bit, first stage read only by second
   always @(posedge clk) begin
      if (rst) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

`default_nettype wire

//--- hw/ujp_user_port.v
// Purpose: Test access port controller with a user port into the fabric
// Assumes: clk is much faster than the test clock; pins are sampled by clk
// Notes: Test clock edges are found by sampling; registered outputs lag the pins by
//        the synchroniser delay plus one cycle, the serial input and test clock by the delay alone
// Notes on behaviour
// (RULE1) User port always live, no test mode
// (RULE2) Eight-bit instruction bus to fabric
// (RULE3) Fabric defines codes 16 to 127 only
// (RULE4) Reset out low in Test-Logic-Reset
// (RULE5) Power-on reset forces Test-Logic-Reset
// (RULE6) Reset held until tester leaves reset
// (RULE7) Serial input passed to fabric directly
// (RULE8) User serial out reaches TDO in range
// (RULE9) Shift flag high exactly in Shift-DR
// (RULE10) Capture flag high exactly in Capture-DR
// (RULE11) Update flag high exactly in Update-DR
// (RULE12) Test clock passed to fabric directly
// (RULE13) Instruction bus changes only at Update-IR; the code also loads 8'h0f in Test-Logic-Reset and on trst_n low
// (RULE14) Tester holds TMS high five clocks
// (RULE15) State advances on rising test clock
// (RULE16) Fabric qualifies flags with own decode
`default_nettype none
`include "ujp_defs.vh"

module ujp_user_port (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Test port pins
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire trst_n,
   output wire tdo_o,
   output wire tdo_oe,
   // Fabric side
   output wire [7:0] user_instr_bus,
   output wire user_tap_reset_n,
   output wire user_serial_in,
   input wire user_serial_out,
   output wire user_dr_shift_flag,
   output wire user_dr_capture_flag,
   output wire user_dr_update_flag,
   output wire user_dr_clock
);

   // Controller states
   localparam [3:0] ST_TLR = 4'h0;
   localparam [3:0] ST_RTI = 4'h1;
   localparam [3:0] ST_SEL_DR = 4'h2;
   localparam [3:0] ST_CAP_DR = 4'h3;
   localparam [3:0] ST_SH_DR = 4'h4;
   localparam [3:0] ST_EX1_DR = 4'h5;
   localparam [3:0] ST_PAU_DR = 4'h6;
   localparam [3:0] ST_EX2_DR = 4'h7;
   localparam [3:0] ST_UPD_DR = 4'h8;
   localparam [3:0] ST_SEL_IR = 4'h9;
   localparam [3:0] ST_CAP_IR = 4'ha;
   localparam [3:0] ST_SH_IR = 4'hb;
   localparam [3:0] ST_EX1_IR = 4'hc;
   localparam [3:0] ST_PAU_IR = 4'hd;
   localparam [3:0] ST_EX2_IR = 4'he;
   localparam [3:0] ST_UPD_IR = 4'hf;

   // Next state for a given TMS value
   function [3:0] tap_next;
      input [3:0] st;
      input m;
      begin
         case (st)
            ST_TLR: tap_next = m ? ST_TLR : ST_RTI;
            ST_RTI: tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = m ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
            default: tap_next = m ? ST_SEL_DR : ST_RTI;
         endcase
      end
   endfunction

   // True when an instruction code lies in the user range
   function in_user_range;
      input [7:0] code;
      begin
         in_user_range = (code >= `UJP_USER_LO) && (code <= `UJP_USER_HI);
      end
   endfunction

   wire [3:0] pins_s;
   wire tck_s;
   wire tms_s;
   wire tdi_s;
   wire trst_n_s;

   reg tck_prev_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [7:0] ir_shift_q;
   reg [7:0] ir_q;
   reg bypass_q;
   reg [31:0] id_q;
   reg tdo_q;
   reg tdo_oe_q;
   reg reset_n_q;
   reg shift_q;
   reg capture_q;
   reg update_q;

   // Pins pass two flops before any logic reads them
   ujp_sync #(
      .W(4)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in({trst_n, tdi, tms, tck}),
      .sync_out(pins_s)
   );

   assign tck_s = pins_s[0];
   assign tms_s = pins_s[1];
   assign tdi_s = pins_s[2];
   assign trst_n_s = pins_s[3];

   wire tck_rise = tck_s & ~tck_prev_q;
   wire tck_fall = ~tck_s & tck_prev_q;

   // Next state of the controller
   always @* begin
      state_d = state_q;
      if (!trst_n_s) begin
         state_d = ST_TLR;
      end else if (tck_rise) begin
         // (RULE15) advance on rising edge
         state_d = tap_next(state_q, tms_s);
      end
   end

   // Controller state and the flags derived from it
   always @(posedge clk) begin
      if (rst) begin
         // (RULE5) power-on reset state
         state_q <= ST_TLR;
         tck_prev_q <= 1'b0;
         reset_n_q <= 1'b0;
         shift_q <= 1'b0;
         capture_q <= 1'b0;
         update_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tck_prev_q <= tck_s;
         // (RULE4) reset low in Test-Logic-Reset
         // (RULE6) held until state leaves
         reset_n_q <= (state_d != ST_TLR);
         // (RULE9) shift flag decode
         shift_q <= (state_d == ST_SH_DR);
         // (RULE10) capture flag decode
         capture_q <= (state_d == ST_CAP_DR);
         // (RULE11) update flag decode
         update_q <= (state_d == ST_UPD_DR);
      end
   end

   // Instruction and device-owned data registers, acting on rising edges
   always @(posedge clk) begin
      if (rst || !trst_n_s) begin
         ir_shift_q <= `UJP_IR_RESET;
         ir_q <= `UJP_IR_RESET;
         bypass_q <= 1'b0;
         id_q <= `UJP_ID_VALUE;
      end else if (tck_rise) begin
         case (state_q)
            ST_TLR: begin
               ir_q <= `UJP_IR_RESET;
            end
            ST_CAP_IR: begin
               ir_shift_q <= `UJP_IR_CAPTURE;
            end
            ST_SH_IR: begin
               ir_shift_q <= {tdi_s, ir_shift_q[7:1]};
            end
            ST_EX1_IR, ST_EX2_IR: begin
               // (RULE13) bus loads entering Update-IR
               if (tms_s) begin
                  ir_q <= ir_shift_q;
               end
            end
            ST_CAP_DR: begin
               bypass_q <= 1'b0;
               id_q <= `UJP_ID_VALUE;
            end
            ST_SH_DR: begin
               bypass_q <= tdi_s;
               id_q <= {tdi_s, id_q[31:1]};
            end
            default: begin
               ir_q <= ir_q;
            end
         endcase
      end
   end

   // Serial output changes on falling test clock edges
   always @(posedge clk) begin
      if (rst) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_q <= (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
         if (state_q == ST_SH_IR) begin
            tdo_q <= ir_shift_q[0];
         end else if (in_user_range(ir_q)) begin
            // (RULE8) user data to output mux
            tdo_q <= user_serial_out;
         end else if (ir_q == `UJP_OP_IDCODE) begin
            tdo_q <= id_q[0];
         end else begin
            tdo_q <= bypass_q;
         end
      end
   end

   // (RULE1) fabric port always connected
   // (RULE2) current instruction
   assign user_instr_bus = ir_q;
   assign user_tap_reset_n = reset_n_q;
   // (RULE7) serial input straight through
   assign user_serial_in = tdi_s;
   // (RULE12) test clock straight through
   assign user_dr_clock = tck_s;
   assign user_dr_shift_flag = shift_q;
   assign user_dr_capture_flag = capture_q;
   assign user_dr_update_flag = update_q;
   assign tdo_o = tdo_q;
   assign tdo_oe = tdo_oe_q;

endmodule

`default_nettype wire

//--- hw/ujp_user_port_end.v
// Purpose: Marker file closing the design set
// Assumes: Nothing
// Notes: Holds no logic
`default_nettype none
`default_nettype wire

//--- test/ujp_port_chk_assertions.sv
// Purpose: Port checks for the user test port bridge
// Assumes: Pins change away from the clk rising edge
// Notes: Bound to the bridge from the bench
`default_nettype none
module ujp_port_chk (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Watched ports
   input wire tck,
   input wire tdi,
   input wire trst_n,
   input wire tdo_oe,
   input wire [7:0] user_instr_bus,
   input wire user_tap_reset_n,
   input wire user_serial_in,
   input wire user_dr_shift_flag,
   input wire user_dr_capture_flag,
   input wire user_dr_update_flag,
   input wire user_dr_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // Flag, reset and pass-through relations
   a_flags_one: assert property ($onehot0({user_dr_shift_flag, user_dr_capture_flag, user_dr_update_flag}))
      else $error("flags overlap");
   a_reset_quiet: assert property (!user_tap_reset_n |-> !(user_dr_shift_flag || user_dr_update_flag))
      else $error("flag in reset");
   a_trst_forces: assert property ($fell(trst_n) |-> ##[1:6] (!user_tap_reset_n && user_instr_bus == 8'h0f))
      else $error("trst ignored");
   a_leave_reset: assert property ($rose(user_tap_reset_n) |-> user_dr_clock)
      else $error("reset left without clock");
   a_instr_steady: assert property (user_dr_shift_flag && $past(user_dr_shift_flag) |-> $stable(user_instr_bus))
      else $error("instr moved");
   a_serial_thru: assert property (user_serial_in == $past(tdi, 2))
      else $error("serial path");
   a_clock_thru: assert property (user_dr_clock == $past(tck, 2))
      else $error("clock path");
   a_update_entry: assert property ($rose(user_dr_update_flag) |-> !$past(user_dr_shift_flag))
      else $error("update from shift");
   a_oe_shift: assert property (tdo_oe |-> !(user_dr_capture_flag || user_dr_update_flag))
      else $error("tdo driven");
endmodule
`default_nettype wire

//--- test/ujp_fabric_model.sv
// Purpose: Fabric logic answering one user instruction
// Assumes: Flags are valid at the rising user clock
// Notes: Capture value is a parameter
`default_nettype none
module ujp_fabric_model #(
   parameter logic [7:0] CODE = 8'h20,
   parameter logic [7:0] CAP = 8'h3c
) (
   // Fabric side
   input wire logic [7:0] instr,
   input wire logic clk_dr,
   input wire logic sin,
   input wire logic cap,
   input wire logic shift,
   input wire logic upd,
   output logic sout,
   output logic [7:0] held
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sr_q = 8'h00;
   logic [7:0] held_q = 8'h00;
   assign sout = sr_q[0];
   // Latched value seen by the bench
   assign held = held_q;
   always @(posedge clk_dr) begin
      if (instr == CODE) begin
         if (cap) sr_q <= CAP;
         if (shift) sr_q <= {sin, sr_q[7:1]};
         if (upd) held_q <= sr_q;
      end
   end
endmodule
`default_nettype wire

//--- test/ujp_user_port_tb.sv
// Purpose: Self-checking bench for the user test port bridge
// Assumes: Test clock near 65 ns, pins driven at clk falling edges
// Notes: Fabric model answers code 8'h20
`default_nettype none
module ujp_user_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, tck = 0, tms = 1, tdi = 0, trst_n = 1, sout, tdo_o, tdo_oe, rn, sin, sh, cp, up, dck;
   logic [7:0] ir, held, got, fl;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   assign fl = {4'h0, sh, cp, up, rn};
   ujp_user_port u_ujp_user_port (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo_o(tdo_o), .tdo_oe(tdo_oe), .user_instr_bus(ir), .user_tap_reset_n(rn), .user_serial_in(sin),
      .user_serial_out(sout), .user_dr_shift_flag(sh), .user_dr_capture_flag(cp), .user_dr_update_flag(up),
      .user_dr_clock(dck));
   ujp_fabric_model u_ujp_fabric_model (.instr(ir), .clk_dr(dck), .sin(sin), .cap(cp), .shift(sh), .upd(up),
      .sout(sout), .held(held));
   // Clock and hang guard
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      samples_checked++;
      if (a !== e) begin
         error_cnt++;
         $display("ERROR %0t got %h want %h", $time, a, e);
      end
   endtask
   // One test clock period, TDO taken before the rise
   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      repeat (6) @(negedge clk);
      q = tdo_o;
      tck = 1;
      repeat (7) @(negedge clk);
      chk({6'h00, dck, sin}, {7'h01, d});
      tck = 0;
   endtask
   task automatic seq(input logic [7:0] m, input int n);
      logic q;
      for (int i = 0; i < n; i++) tick(m[i], 1'b0, q);
   endtask
   task automatic shift8(input logic [7:0] d, output logic [7:0] o);
      for (int i = 0; i < 8; i++) tick(i == 7, d[i], o[i]);
   endtask
   task automatic t_ir(input logic [7:0] code);
      logic [7:0] old;
      old = ir;
      seq(8'h03, 4);
      shift8(code, got);
      chk(got, 8'h01);
      chk(ir, old);
      seq(8'h01, 1);
      chk(ir, code);
      seq(8'h00, 1);
      chk(ir, code);
      $display("ir %h done", code);
   endtask
   task automatic t_dr(input logic [7:0] d, input logic [7:0] e);
      seq(8'h01, 2);
      chk(fl, 8'h05);
      seq(8'h00, 1);
      chk(fl, 8'h09);
      shift8(d, got);
      chk(got, e);
      chk(fl, 8'h01);
      seq(8'h01, 1);
      chk(fl, 8'h03);
      seq(8'h00, 1);
      $display("dr %h done", d);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(negedge clk);
      rst = 0;
      repeat (40) @(negedge clk);
      chk(fl, 8'h00);
      chk(ir, 8'h0f);
      seq(8'h00, 1);
      chk(fl, 8'h01);
      t_ir(8'h20);
      t_dr(8'ha5, 8'h3c);
      chk(held, 8'ha5);
      t_ir(8'hff);
      t_dr(8'h5a, 8'hb4);
      t_ir(8'h7f);
      t_dr(8'h00, 8'hff);
      t_ir(8'h80);
      t_dr(8'h0f, 8'h1e);
      chk(held, 8'ha5);
      seq(8'h01, 3);
      seq(8'h1f, 5);
      chk(fl, 8'h00);
      seq(8'h01, 1);
      chk(ir, 8'h0f);
      seq(8'h00, 1);
      t_ir(8'h20);
      trst_n = 0;
      repeat (10) @(negedge clk);
      chk(fl, 8'h00);
      chk(ir, 8'h0f);
      trst_n = 1;
      $display("reset paths done");
      results();
   end
endmodule
bind ujp_user_port ujp_port_chk u_ujp_port_chk (.clk(clk), .rst(rst), .tck(tck), .tdi(tdi), .trst_n(trst_n),
   .tdo_oe(tdo_oe), .user_instr_bus(user_instr_bus), .user_tap_reset_n(user_tap_reset_n),
   .user_serial_in(user_serial_in), .user_dr_shift_flag(user_dr_shift_flag),
   .user_dr_capture_flag(user_dr_capture_flag), .user_dr_update_flag(user_dr_update_flag),
   .user_dr_clock(user_dr_clock));
`default_nettype wire
